// ---- dv/motor_side_model.sv ----
// Purpose: Control contact, kick pin and fault pins of the far side.
// Assumes: Commands change on the rising clock edge.
// Notes:   Pins follow the commands one clock later, like a relay.
`timescale 1ns/1ps
module motor_side_model (
  input  wire logic       mclk,
  input  wire logic       run_cmd,
  input  wire logic       kick_cmd,
  input  wire logic [7:0] fault_cmd,
  output logic            start_stop_input = 1'b0,
  output logic            kick_boost_input = 1'b0,
  output logic [7:0]      fault_sense = 8'h00
);
  // A closed contact asks for a soft start, an open one for a soft stop.
  always @(posedge mclk) begin
    start_stop_input <= run_cmd;
    kick_boost_input <= kick_cmd;
  end

  // Fault pins follow the commands; clearing the latch takes a power cycle.
  always @(posedge mclk) begin
    fault_sense <= fault_cmd;
  end
endmodule

// ---- dv/softstart_seq_monitor.sv ----
// Purpose: Concurrent checks on the soft starter sequencer outputs.
// Assumes: One clock mclk and the synchronous active high rst.
// Notes:   Bound into every softstart_seq instance below.
`timescale 1ns/1ps
module softstart_seq_monitor #(
  parameter int MS_CYCLES = 4
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       start_stop_input,
  input wire logic [7:0] fault_sense,
  input wire logic [7:0] phase1_drive,
  input wire logic [7:0] phase3_drive,
  input wire logic       bypass_relay_contacts,
  input wire logic       fault_relay_contacts,
  input wire logic       green_lamp,
  input wire logic       yellow_lamp
);
  logic [3:0] quiet;
  logic       run_q;
  logic [7:0] sense_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Last pin levels, so that a pin change restarts the quiet count.
  always_ff @(posedge mclk) begin
    run_q   <= start_stop_input;
    sense_q <= fault_sense;
  end

  // Cycles since the contact or a fault pin last moved, saturating.
  always_ff @(posedge mclk) begin
    if (rst || run_q != start_stop_input || sense_q != fault_sense) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hF) begin
      quiet <= quiet + 4'h1;
    end
  end

  AST_PHASE_EQ: assert property (phase1_drive == phase3_drive)
    else $error("controlled phases differ");
  AST_STEP_UP: assert property (quiet == 4'hF && start_stop_input &&
    $past(phase1_drive) != 8'h00 && phase1_drive != 8'hFF &&
    phase1_drive > $past(phase1_drive)
    |-> phase1_drive == $past(phase1_drive) + 8'h01)
    else $error("start ramp jumped");
  AST_STEP_DOWN: assert property (quiet == 4'hF && !start_stop_input &&
    fault_sense == 8'h00 && phase1_drive < $past(phase1_drive)
    |-> phase1_drive == $past(phase1_drive) - 8'h01)
    else $error("stop ramp jumped");
  AST_BYP_FULL: assert property (bypass_relay_contacts
    |-> phase1_drive == 8'hFF && !fault_relay_contacts)
    else $error("bypass without full drive");
  AST_YEL_STEADY: assert property ($past(bypass_relay_contacts) &&
    bypass_relay_contacts |-> yellow_lamp)
    else $error("yellow not steady in bypass");
  AST_GREEN: assert property (!$past(rst) && !$past(rst, 2) &&
    !$past(rst, 3) |-> green_lamp == !fault_relay_contacts)
    else $error("green lamp wrong");
  AST_FAULT_SAFE: assert property (fault_relay_contacts &&
    $past(fault_relay_contacts) |-> !bypass_relay_contacts &&
    phase1_drive == 8'h00)
    else $error("drive or bypass active in fault");
  AST_FAULT_HOLD: assert property (fault_relay_contacts
    |=> fault_relay_contacts)
    else $error("fault relay dropped");
  AST_FAULT_ENTRY: assert property ((fault_sense != 8'h00)[*3]
    |-> ##[0:6] fault_relay_contacts)
    else $error("fault relay late");
endmodule

bind softstart_seq softstart_seq_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (
  .mclk(mclk), .rst(rst), .start_stop_input(start_stop_input),
  .fault_sense(fault_sense), .phase1_drive(phase1_drive),
  .phase3_drive(phase3_drive), .bypass_relay_contacts(bypass_relay_contacts),
  .fault_relay_contacts(fault_relay_contacts), .green_lamp(green_lamp),
  .yellow_lamp(yellow_lamp));

// ---- dv/softstart_status_fault_indicator_test.sv ----
// Purpose: Self-checking bench for the soft starter sequencer.
// Assumes: Short millisecond tick through MS_CYCLES.
// Notes:   Each fault code is entered after its own power cycle.
`timescale 1ns/1ps
module softstart_status_fault_indicator_test;
  import softstart_pkg::*;
  localparam int MSC = 2;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        run = 1'b0;
  logic        kick = 1'b0;
  logic [7:0]  fcmd = 8'h00;
  logic        ssi;
  logic        kbi;
  logic [7:0]  fs;
  axil_req_s   req = '0;
  axil_resp_s  resp;
  logic [7:0]  ph1;
  logic [7:0]  ph3;
  logic        byp;
  logic        flt;
  logic        grn;
  logic        yel;
  logic [31:0] rd;
  logic [1:0]  rr;
  int          err_count = 0;
  int          n_checks = 0;
  int          tog;
  int          cyc;

  // Clock toggles every 12.5 ns, half of its 25 ns period.
  always #12.5 mclk = ~mclk;

  motor_side_model u_motor (.mclk(mclk), .run_cmd(run), .kick_cmd(kick),
    .fault_cmd(fcmd), .start_stop_input(ssi), .kick_boost_input(kbi),
    .fault_sense(fs));
  softstart_seq #(.MS_CYCLES(MSC)) u_dut (.mclk(mclk), .rst(rst),
    .start_stop_input(ssi), .kick_boost_input(kbi), .fault_sense(fs),
    .axil_req(req), .axil_resp(resp), .phase1_drive(ph1),
    .phase3_drive(ph3), .bypass_relay_contacts(byp),
    .fault_relay_contacts(flt), .green_lamp(grn), .yellow_lamp(yel));

  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Power cycle: reset held for six clocks.
  task automatic do_reset;
    @(posedge mclk);
    rst <= 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  // AXI4-Lite write; each channel is held until its ready is sampled.
  task automatic axw(input logic [31:0] a, d, input logic [1:0] er);
    bit aw;
    bit w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge mclk);
    req.awaddr  <= a;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge mclk);
      if (resp.awready) aw = 1'b1;
      if (resp.wready) w = 1'b1;
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
    end
    do @(posedge mclk); while (resp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    chk("bresp", er, resp.bresp);
  endtask

  // AXI4-Lite read; data and response are left in rd and rr.
  task automatic axr(input logic [31:0] a);
    @(posedge mclk);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (resp.arready) req.arvalid <= 1'b0;
    end while (resp.rvalid !== 1'b1);
    rd = resp.rdata;
    rr = resp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic rdchk(input logic [31:0] a, ed, input logic [1:0] er);
    axr(a);
    chk("rdata", ed, rd);
    chk("rresp", er, rr);
  endtask

  function automatic logic hit(input int s);
    case (s)
      0: hit = byp;
      1: hit = (ph1 == 8'h00);
      2: hit = (ph1 != 8'hFF);
      3: hit = (ph1 == 8'hFF);
      default: hit = flt;
    endcase
  endfunction

  // Waits for a condition, counting cycles and yellow lamp changes.
  task automatic wait_hit(input int s, input int lim);
    logic prev;
    prev = yel;
    tog = 0;
    cyc = 0;
    while (hit(s) !== 1'b1 && cyc < lim) begin
      @(posedge mclk);
      cyc++;
      if (yel !== prev) tog++;
      prev = yel;
    end
    chk("wait", 1'b1, hit(s));
  endtask

  // Measures one flash burst and its pause, starting at fault entry.
  task automatic burst(input int code);
    int hi;
    int lo;
    int k;
    k = 0;
    lo = 0;
    for (int i = 0; i < 3 && yel !== 1'b1; i++) @(posedge mclk);
    while (lo <= 2 * FLASH_MS * MSC && k < 9) begin
      hi = 0;
      lo = 0;
      while (yel === 1'b1 && hi < PAUSE_MS * MSC) begin
        hi++;
        @(posedge mclk);
      end
      while (yel === 1'b0 && lo < PAUSE_MS * MSC + 8) begin
        lo++;
        @(posedge mclk);
      end
      k++;
      chk("flash on", FLASH_MS * MSC, hi);
      if (lo <= 2 * FLASH_MS * MSC) chk("flash off", FLASH_MS * MSC, lo);
      else chk("pause", PAUSE_MS * MSC, lo);
    end
    chk("flash count", code, k);
  endtask

  // Cuts a hang short.
  initial begin
    repeat (90000) @(posedge mclk);
    err_count++;
    summarize();
  end

  // Main sequence.
  initial begin
    do_reset();
    chk("green", 1'b1, grn);
    chk("yellow idle", 1'b0, yel);
    rdchk(UP_DIV_OFS, {16'h0000, UP_DIV_RST}, RESP_OKAY);
    rdchk(DOWN_DIV_OFS, {16'h0000, DOWN_DIV_RST}, RESP_OKAY);
    rdchk(START_LVL_OFS, {24'h00_0000, START_LVL_RST}, RESP_OKAY);
    rdchk(STATUS_OFS, 32'h0000_0001, RESP_OKAY);
    rdchk(32'h0000_0010, 32'h0000_0000, RESP_SLVERR);
    axw(UP_DIV_OFS, 32'h0000_0003, RESP_OKAY);
    rdchk(UP_DIV_OFS, 32'h0000_0003, RESP_OKAY);
    axw(STATUS_OFS, 32'hFFFF_FFFF, RESP_OKAY);
    axw(32'h0000_0010, 32'h0000_0005, RESP_SLVERR);
    rdchk(STATUS_OFS, 32'h0000_0001, RESP_OKAY);
    @(posedge mclk) run <= 1'b1;
    wait_hit(0, 8000);
    chk("ramp blink up", 1'b1, tog > 0);
    repeat (4) @(posedge mclk);
    chk("steady yellow", 1'b1, yel);
    rdchk(STATUS_OFS, 32'h00FF_0008, RESP_OKAY);
    @(posedge mclk) run <= 1'b0;
    wait_hit(1, 8000);
    chk("ramp blink down", 1'b1, tog > 0);
    chk("stop slow", 1'b1, cyc > 255);
    chk("bypass open", 1'b0, byp);
    repeat (20) @(posedge mclk);
    @(posedge mclk) kick <= 1'b1;
    @(posedge mclk) run <= 1'b1;
    wait_hit(3, 20);
    wait_hit(2, KICK_MS * MSC + 20);
    chk("kick time", 1'b1, cyc >= KICK_MS * MSC - MSC - 1 &&
      cyc <= KICK_MS * MSC + MSC + 1);
    chk("kick end", START_LVL_RST, ph1);
    @(posedge mclk) kick <= 1'b0;
    @(posedge mclk) run <= 1'b0;
    wait_hit(1, 4000);
    for (int c = 1; c <= 8; c++) begin
      do_reset();
      if (c == 8) @(posedge mclk) run <= 1'b1;
      repeat (40) @(posedge mclk);
      fcmd <= 8'h01 << (c - 1);
      wait_hit(4, 40);
      burst(c);
      @(posedge mclk) fcmd <= fcmd | ((c == 1) ? 8'h80 : 8'h01);
      repeat (20) @(posedge mclk);
      axr(STATUS_OFS);
      chk("code", c, rd[11:8]);
      chk("state", 32'h0000_0020, rd[5:0]);
      @(posedge mclk) fcmd <= 8'h00;
      repeat (20) @(posedge mclk);
      chk("fault kept", 1'b1, flt);
      chk("green off", 1'b0, grn);
      chk("drive off", 8'h00, ph1);
    end
    summarize();
  end
endmodule

// ---- hw/softstart_pkg.sv ----
// Purpose: Shared constants and carriers for the soft starter sequencer.
// Assumes: One 40 MHz clock, AXI4-Lite register access with 32-bit data.
// Notes:   All times are kept in their own unit; only the tick is converted to cycles here.
package softstart_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ     = 40;
  localparam int TICK_US     = 1000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int KICK_MS     = 500;
  localparam int FLASH_MS    = 250;
  localparam int PAUSE_MS    = 1000;
  localparam int BLINK_MIN   = 16;

  // ----------------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] UP_DIV_OFS    = 32'h0000_0000;
  localparam logic [31:0] DOWN_DIV_OFS  = 32'h0000_0004;
  localparam logic [31:0] START_LVL_OFS = 32'h0000_0008;
  localparam logic [31:0] STATUS_OFS    = 32'h0000_000C;
  localparam logic [15:0] UP_DIV_RST    = 16'h0004;
  localparam logic [15:0] DOWN_DIV_RST  = 16'h0004;
  localparam logic [7:0]  START_LVL_RST = 8'h40;
  localparam logic [7:0]  LEVEL_FULL    = 8'hFF;
  localparam int          STAT_CODE_POS = 8;
  localparam int          STAT_LVL_POS  = 16;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE      = 6'h01,
    ST_KICK      = 6'h02,
    ST_RAMP_UP   = 6'h04,
    ST_BYPASS    = 6'h08,
    ST_RAMP_DOWN = 6'h10,
    ST_FAULT     = 6'h20
  } seq_state_e;

  // ----------------------------------------------------------------------
  // AXI4-Lite carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axil_resp_s;

endpackage

// ---- hw/softstart_seq.sv ----
// Purpose: Start/stop ramp sequencing, bypass, lamps and fault latching.
// Assumes: Pins are asynchronous and are filtered by three flip-flops.
// Notes:   Faults clear only through rst, which stands for power-on.
`timescale 1ns/1ps

module softstart_seq #(
  parameter int MS_CYCLES = softstart_pkg::TICK_CYCLES
) (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      start_stop_input,
  input  wire logic                      kick_boost_input,
  input  wire logic [7:0]                fault_sense,
  input  wire softstart_pkg::axil_req_s  axil_req,
  output softstart_pkg::axil_resp_s      axil_resp,
  output logic [7:0]                     phase1_drive,
  output logic [7:0]                     phase3_drive,
  output logic                           bypass_relay_contacts,
  output logic                           fault_relay_contacts,
  output logic                           green_lamp,
  output logic                           yellow_lamp
);
  import softstart_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [9:0]  sync1;
  logic [9:0]  sync2;
  logic [9:0]  sync3;
  logic [9:0]  pins;
  logic [15:0] tick_cnt;
  logic        ms_tick;
  logic [15:0] up_div;
  logic [15:0] down_div;
  logic [7:0]  start_lvl;
  seq_state_e  state;
  seq_state_e  next_state;
  logic [7:0]  level;
  logic [15:0] step_cnt;
  logic [9:0]  kick_cnt;
  logic [3:0]  fault_code;
  logic [3:0]  next_code;
  logic [13:0] blink_acc;
  logic        blink;
  logic        fl_on;
  logic [3:0]  fl_num;
  logic [9:0]  fl_cnt;
  logic        aw_got;
  logic        w_got;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        run_req;
  logic        step_due;

  // Applies byte enables of a write to a register image.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // Pin filtering and time base
  // ----------------------------------------------------------------------
  // Three-stage synchroniser; a change is accepted when stages two and
  // three agree, so a single metastable sample never reaches the logic.
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1 <= 10'h000;
      sync2 <= 10'h000;
      sync3 <= 10'h000;
      pins  <= 10'h000;
    end else begin
      sync1 <= {fault_sense, kick_boost_input, start_stop_input};
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < 10; i++) begin
        if (sync2[i] == sync3[i]) begin
          pins[i] <= sync3[i];
        end
      end
    end
  end

  // Closed contact requests a start, open contact a stop.
  assign run_req  = pins[0];
  assign step_due = ms_tick &&
    (step_cnt >= ((state == ST_RAMP_DOWN) ? down_div : up_div) - 16'h0001);

  // Millisecond enable pulse for all slow timing.
  always_ff @(posedge mclk) begin
    if (rst) begin
      tick_cnt <= 16'h0000;
      ms_tick  <= 1'b0;
    end else if (tick_cnt == 16'(MS_CYCLES - 1)) begin
      tick_cnt <= 16'h0000;
      ms_tick  <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      ms_tick  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Fault latch
  // ----------------------------------------------------------------------
  // Lowest asserted source gives the code; bit i reports code i+1.
  always_comb begin
    next_code = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (pins[2+i]) begin
        next_code = 4'(i + 1);
      end
    end
  end

  // Code is held from the first fault until power-on reset only.
  always_ff @(posedge mclk) begin
    if (rst) begin
      fault_code <= 4'h0;
    end else if (fault_code == 4'h0) begin
      fault_code <= next_code;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Next state of the start/stop sequence.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (run_req) begin
          next_state = pins[1] ? ST_KICK : ST_RAMP_UP;
        end
      end
      ST_KICK: begin
        if (!run_req) begin
          next_state = ST_RAMP_DOWN;
        end else if (ms_tick && kick_cnt == 10'(KICK_MS - 1)) begin
          next_state = ST_RAMP_UP;
        end
      end
      ST_RAMP_UP: begin
        if (!run_req) begin
          next_state = ST_RAMP_DOWN;
        end else if (step_due && level == LEVEL_FULL) begin
          next_state = ST_BYPASS;
        end
      end
      ST_BYPASS: begin
        if (!run_req) begin
          next_state = ST_RAMP_DOWN;
        end
      end
      ST_RAMP_DOWN: begin
        if (run_req) begin
          next_state = ST_RAMP_UP;
        end else if (step_due && level == 8'h00) begin
          next_state = ST_IDLE;
        end
      end
      ST_FAULT: begin
        next_state = ST_FAULT;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (fault_code != 4'h0 || next_code != 4'h0) begin
      next_state = ST_FAULT;
    end
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Kick interval counter in milliseconds.
  always_ff @(posedge mclk) begin
    if (rst || state != ST_KICK) begin
      kick_cnt <= 10'h000;
    end else if (ms_tick) begin
      kick_cnt <= kick_cnt + 10'h001;
    end
  end

  // Ramp level: steps once per divider period, up or down.
  always_ff @(posedge mclk) begin
    if (rst) begin
      level    <= 8'h00;
      step_cnt <= 16'h0000;
    end else begin
      if (ms_tick) begin
        step_cnt <= step_due ? 16'h0000 : step_cnt + 16'h0001;
      end
      case (next_state)
        ST_IDLE, ST_FAULT: begin
          level <= 8'h00;
        end
        ST_KICK, ST_BYPASS: begin
          level <= LEVEL_FULL;
        end
        ST_RAMP_UP: begin
          if (state == ST_IDLE || state == ST_KICK) begin
            level <= start_lvl;
          end else if (step_due && level != LEVEL_FULL) begin
            level <= level + 8'h01;
          end
        end
        ST_RAMP_DOWN: begin
          if (step_due && level != 8'h00) begin
            level <= level - 8'h01;
          end
        end
        default: begin
          level <= 8'h00;
        end
      endcase
    end
  end

  // Drive and relay outputs; phase two is never controlled.
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase1_drive          <= 8'h00;
      phase3_drive          <= 8'h00;
      bypass_relay_contacts <= 1'b0;
      fault_relay_contacts  <= 1'b0;
    end else begin
      phase1_drive          <= level;
      phase3_drive          <= level;
      bypass_relay_contacts <= (state == ST_BYPASS);
      fault_relay_contacts  <= (state == ST_FAULT);
    end
  end

  // ----------------------------------------------------------------------
  // Lamps
  // ----------------------------------------------------------------------
  // Blink accumulator: higher level overflows sooner, so blink is faster.
  always_ff @(posedge mclk) begin
    if (rst) begin
      blink_acc <= 14'h0000;
      blink     <= 1'b0;
    end else if (ms_tick) begin
      {blink, blink_acc} <= {1'b0, blink_acc} +
                            15'({7'h00, level}) + 15'(BLINK_MIN) +
                            {blink, 14'h0000};
    end
  end

  // Fault flash train: code flashes at a fixed rate, then a pause.
  // The train starts on a tick, so the first flash is full length too.
  always_ff @(posedge mclk) begin
    if (rst || state != ST_FAULT) begin
      fl_on  <= 1'b0;
      fl_num <= 4'h0;
      fl_cnt <= 10'h000;
    end else if (ms_tick) begin
      if (fl_num == 4'h0) begin
        fl_on  <= 1'b1;
        fl_num <= 4'h1;
        fl_cnt <= 10'h000;
      end else if (fl_on && fl_cnt == 10'(FLASH_MS - 1)) begin
        fl_on  <= 1'b0;
        fl_cnt <= 10'h000;
      end else if (!fl_on && fl_num == fault_code &&
                   fl_cnt == 10'(PAUSE_MS - 1)) begin
        fl_on  <= 1'b1;
        fl_num <= 4'h1;
        fl_cnt <= 10'h000;
      end else if (!fl_on && fl_num != fault_code &&
                   fl_cnt == 10'(FLASH_MS - 1)) begin
        fl_on  <= 1'b1;
        fl_num <= fl_num + 4'h1;
        fl_cnt <= 10'h000;
      end else begin
        fl_cnt <= fl_cnt + 10'h001;
      end
    end
  end

  // Lamp outputs with fault indication taking priority.
  always_ff @(posedge mclk) begin
    if (rst) begin
      green_lamp  <= 1'b0;
      yellow_lamp <= 1'b0;
    end else begin
      green_lamp <= (state != ST_FAULT);
      case (state)
        ST_FAULT:   yellow_lamp <= fl_on;
        ST_BYPASS:  yellow_lamp <= 1'b1;
        ST_IDLE:    yellow_lamp <= 1'b0;
        default:    yellow_lamp <= blink;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  // Write channel: address and data are accepted in either order.
  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_got            <= 1'b0;
      w_got             <= 1'b0;
      aw_addr           <= 32'h0000_0000;
      w_data            <= 32'h0000_0000;
      w_strb            <= 4'h0;
      axil_resp.awready <= 1'b0;
      axil_resp.wready  <= 1'b0;
      axil_resp.bvalid  <= 1'b0;
      axil_resp.bresp   <= RESP_OKAY;
      up_div            <= UP_DIV_RST;
      down_div          <= DOWN_DIV_RST;
      start_lvl         <= START_LVL_RST;
    end else begin
      axil_resp.awready <= 1'b0;
      axil_resp.wready  <= 1'b0;
      if (axil_req.awvalid && !aw_got && !axil_resp.awready) begin
        axil_resp.awready <= 1'b1;
        aw_got            <= 1'b1;
        aw_addr           <= axil_req.awaddr;
      end
      if (axil_req.wvalid && !w_got && !axil_resp.wready) begin
        axil_resp.wready <= 1'b1;
        w_got            <= 1'b1;
        w_data           <= axil_req.wdata;
        w_strb           <= axil_req.wstrb;
      end
      if (aw_got && w_got && !axil_resp.bvalid) begin
        axil_resp.bvalid <= 1'b1;
        axil_resp.bresp  <= RESP_OKAY;
        case (aw_addr)
          UP_DIV_OFS:    up_div    <= 16'(merge({16'h0000, up_div},
                                                w_data, w_strb));
          DOWN_DIV_OFS:  down_div  <= 16'(merge({16'h0000, down_div},
                                                w_data, w_strb));
          START_LVL_OFS: start_lvl <= 8'(merge({24'h000000, start_lvl},
                                               w_data, w_strb));
          STATUS_OFS:    axil_resp.bresp <= RESP_OKAY;
          default:       axil_resp.bresp <= RESP_SLVERR;
        endcase
      end
      if (axil_resp.bvalid && axil_req.bready) begin
        axil_resp.bvalid <= 1'b0;
        aw_got           <= 1'b0;
        w_got            <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time, data registered with the answer.
  always_ff @(posedge mclk) begin
    if (rst) begin
      axil_resp.arready <= 1'b0;
      axil_resp.rvalid  <= 1'b0;
      axil_resp.rdata   <= 32'h0000_0000;
      axil_resp.rresp   <= RESP_OKAY;
    end else begin
      axil_resp.arready <= 1'b0;
      if (axil_req.arvalid && !axil_resp.rvalid && !axil_resp.arready) begin
        axil_resp.arready <= 1'b1;
        axil_resp.rvalid  <= 1'b1;
        axil_resp.rresp   <= RESP_OKAY;
        case (axil_req.araddr)
          UP_DIV_OFS:    axil_resp.rdata <= {16'h0000, up_div};
          DOWN_DIV_OFS:  axil_resp.rdata <= {16'h0000, down_div};
          START_LVL_OFS: axil_resp.rdata <= {24'h000000, start_lvl};
          STATUS_OFS: begin
            axil_resp.rdata <= 32'h0000_0000;
            axil_resp.rdata[5:0] <= state;
            axil_resp.rdata[STAT_CODE_POS +: 4] <= fault_code;
            axil_resp.rdata[STAT_LVL_POS +: 8]  <= level;
          end
          default: begin
            axil_resp.rdata <= 32'h0000_0000;
            axil_resp.rresp <= RESP_SLVERR;
          end
        endcase
      end else if (axil_resp.rvalid && axil_req.rready) begin
        axil_resp.rvalid <= 1'b0;
      end
    end
  end

endmodule
